// ### core/dgc_regs.svh
`ifndef DGC_REGS_SVH
`define DGC_REGS_SVH
// Register byte offsets
`define DGC_OFF_CTRL      8'h00
`define DGC_OFF_SLOT0     8'h04
`define DGC_OFF_SLOT1     8'h08
`define DGC_OFF_TIMING    8'h0c
`define DGC_OFF_STATUS    8'h10
`define DGC_OFF_ADDR      8'h14
`define DGC_OFF_DECODE    8'h18
`define DGC_OFF_CMD       8'h1c
// CTRL fields
`define DGC_CTRL_DDR3     0
`define DGC_CTRL_RATE     1
`define DGC_CTRL_ENABLE   2
`define DGC_CTRL_DRST     3
// SLOT fields: [0] present, [1] two ranks, [2] x16, [4:3] density code
`define DGC_SLOT_PRES     0
`define DGC_SLOT_DUAL     1
`define DGC_SLOT_X16      2
`define DGC_SLOT_DEN_LO   3
// TIMING fields, four bytes from the top: cas, trcd, tras, trp in memory clocks
`define DGC_CTRL_RST      32'h0000_0008
`define DGC_TIMING_RST    32'h0f05_0505
// Rates in MT/s
`define DGC_RATE_667      16'd667
`define DGC_RATE_800      16'd800
`endif

// ### core/dgc_pkg.sv
package dgc_pkg;
    typedef enum logic [1:0] {
        DGC_DEN_256M = 2'b00,
        DGC_DEN_512M = 2'b01,
        DGC_DEN_1G   = 2'b10,
        DGC_DEN_2G   = 2'b11
    } dgc_den_t;
    typedef enum logic [2:0] {
        DGC_IDLE = 3'b000,
        DGC_ACT  = 3'b001,
        DGC_RCD  = 3'b010,
        DGC_RW   = 3'b011,
        DGC_RAS  = 3'b100,
        DGC_PRE  = 3'b101,
        DGC_REF  = 3'b110
    } dgc_state_t;
    typedef enum logic [2:0] {
        DGC_C_NOP = 3'b000,
        DGC_C_ACT = 3'b001,
        DGC_C_RD  = 3'b010,
        DGC_C_WR  = 3'b011,
        DGC_C_PRE = 3'b100,
        DGC_C_REF = 3'b101
    } dgc_cmd_t;
endpackage

// ### core/dgc_geom.sv
`timescale 1ns/100ps
`default_nettype none
// Geometry lookup for one module slot
module dgc_geom
    import dgc_pkg::*;
(
    input  wire logic       x16,
    input  wire logic [1:0] den,
    input  wire logic       ddr3,
    output logic            bank8,
    output logic [1:0]      col_bits_m9,
    output logic [1:0]      row_bits_m13,
    output logic [3:0]      rank_mb_log2,
    output logic            legal
);
    // Columns, banks, rows and rank capacity per density and width
    always_comb begin
        bank8        = 1'b1;
        col_bits_m9  = 2'd1;
        row_bits_m13 = 2'd1;
        rank_mb_log2 = 4'd0;
        legal        = 1'b1;
        case (dgc_den_t'(den))
            DGC_DEN_256M: begin
                bank8        = 1'b0;
                col_bits_m9  = x16 ? 2'd0 : 2'd1;
                row_bits_m13 = 2'd0;
                rank_mb_log2 = x16 ? 4'd7 : 4'd8;
                legal        = !ddr3;
            end
            DGC_DEN_512M: begin
                bank8        = x16;
                row_bits_m13 = 2'd1;
                rank_mb_log2 = x16 ? 4'd8 : 4'd9;
                legal        = !ddr3;
            end
            DGC_DEN_1G: begin
                row_bits_m13 = x16 ? 2'd0 : 2'd1;
                rank_mb_log2 = x16 ? 4'd9 : 4'd10;
            end
            DGC_DEN_2G: begin
                row_bits_m13 = x16 ? 2'd0 : 2'd1;
                rank_mb_log2 = x16 ? 4'd10 : 4'd11;
            end
            default: begin
                legal = 1'b0;
            end
        endcase
    end
endmodule
`default_nettype wire

// ### core/dgc_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "dgc_regs.svh"
// Overview of operation
// - One 64-bit channel only; every cycle goes to it, serving both slots.
// - Up to two modules, single or dual rank, decoding up to four ranks.
// - DDR2 runs at 667 or 800 MT/s, non-ECC modules only.
// - DDR3 runs only at 800 MT/s with unbuffered non-ECC SO-DIMMs.
// - DDR2 builds: single x16, single x8, double x8.
// - Ranks counted by chip selects wired, not component placement.
// - 4Gb and 8Gb devices are not decoded.
// - 256Mb: 4 banks, 8K rows; x8 1K cols 256MB, x16 512 cols 128MB.
// - 512Mb: 1K cols, 16K rows; x8 4 banks 512MB, x16 8 banks 256MB.
// - 1Gb: 8 banks, 1K cols; x8 16K rows 1GB, x16 8K rows 512MB.
// - 2Gb: 8 banks, 1K cols; x8 16K rows 2GB, x16 8K rows 1GB.
// - DDR3 builds: two ranks x16 or one rank x8, eight banks.
// - DDR3 uses standard 1Gb and 2Gb addressing, 1GB or 2GB modules.
// - Any slot may be populated, in any order.
// - DDR3 drives one active-low DRAM reset output; unused for DDR2.
module dgc_top
    import dgc_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             dram_reset_out_n,
    output logic [3:0]       dram_cs_n,
    output logic [2:0]       dram_cmd,
    output logic [2:0]       dram_ba,
    output logic [13:0]      dram_addr
);
    logic [31:0] ctrl_reg;
    logic [31:0] slot0_reg;
    logic [31:0] slot1_reg;
    logic [31:0] timing_reg;
    logic [31:0] addr_reg;
    logic [31:0] cmd_reg;
    logic        aw_got_reg;
    logic        w_got_reg;
    logic [7:0]  aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        wr_fire;
    logic        cfg_err_reg;
    logic [1:0]  dec_rank_reg;
    logic [2:0]  dec_bank_reg;
    logic [13:0] dec_row_reg;
    logic [9:0]  dec_col_reg;
    logic        dec_hit_reg;
    dgc_state_t  state_reg;
    logic [7:0]  tcnt_reg;
    logic        busy_reg;
    logic        go_start;

    // Byte-lane merge shared by every writable register
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Rank count of a slot: chip selects wired, not component sides
    function automatic logic [1:0] ranks(input logic [31:0] s);
        return s[`DGC_SLOT_PRES] ? (s[`DGC_SLOT_DUAL] ? 2'd2 : 2'd1) : 2'd0;
    endfunction

    // Slot build allowed by the selected memory type
    function automatic logic build_ok(input logic [31:0] s, input logic ddr3);
        logic r;
        r = 1'b1;
        if (s[`DGC_SLOT_PRES]) begin
            if (ddr3) begin
                r = (s[`DGC_SLOT_X16] == s[`DGC_SLOT_DUAL]);
            end else begin
                r = !(s[`DGC_SLOT_X16] && s[`DGC_SLOT_DUAL]);
            end
        end
        return r;
    endfunction

    logic       g0_b8;
    logic [1:0] g0_col;
    logic [1:0] g0_row;
    logic [3:0] g0_mb;
    logic       g0_ok;
    logic       g1_b8;
    logic [1:0] g1_col;
    logic [1:0] g1_row;
    logic [3:0] g1_mb;
    logic       g1_ok;
    logic       ddr3;

    assign ddr3 = ctrl_reg[`DGC_CTRL_DDR3];

    // Sequencer start; a go bit written while busy stays pending until this fires
    assign go_start = state_reg == DGC_IDLE && cmd_reg[0] && !busy_reg
                      && ctrl_reg[`DGC_CTRL_ENABLE] && !cfg_err_reg
                      && (cmd_reg[2] || dec_hit_reg);

    dgc_geom u_geom0 (
        .x16          (slot0_reg[`DGC_SLOT_X16]),
        .den          (slot0_reg[`DGC_SLOT_DEN_LO +: 2]),
        .ddr3         (ddr3),
        .bank8        (g0_b8),
        .col_bits_m9  (g0_col),
        .row_bits_m13 (g0_row),
        .rank_mb_log2 (g0_mb),
        .legal        (g0_ok)
    );
    dgc_geom u_geom1 (
        .x16          (slot1_reg[`DGC_SLOT_X16]),
        .den          (slot1_reg[`DGC_SLOT_DEN_LO +: 2]),
        .ddr3         (ddr3),
        .bank8        (g1_b8),
        .col_bits_m9  (g1_col),
        .row_bits_m13 (g1_row),
        .rank_mb_log2 (g1_mb),
        .legal        (g1_ok)
    );

    // Write channel: address and data accepted in either order
    assign wr_fire = aw_got_reg && w_got_reg && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg    <= 1'b0;
            w_got_reg     <= 1'b0;
            aw_addr_reg   <= 8'h00;
            w_data_reg    <= 32'h0000_0000;
            w_strb_reg    <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
        end else begin
            s_axi_awready <= !aw_got_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_got_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_reg  <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_reg  <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_got_reg   <= 1'b0;
                w_got_reg    <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_reg[1:0] == 2'b00 &&
                                 aw_addr_reg <= `DGC_OFF_CMD) ? 2'b00 : 2'b10;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Configuration registers; status and decode are read-only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg   <= `DGC_CTRL_RST;
            slot0_reg  <= 32'h0000_0000;
            slot1_reg  <= 32'h0000_0000;
            timing_reg <= `DGC_TIMING_RST;
            addr_reg   <= 32'h0000_0000;
            cmd_reg    <= 32'h0000_0000;
        end else begin
            if (go_start) begin
                cmd_reg[0] <= 1'b0;
            end
            if (wr_fire) begin
                case (aw_addr_reg)
                    `DGC_OFF_CTRL:   ctrl_reg   <= merge(ctrl_reg, w_data_reg, w_strb_reg);
                    `DGC_OFF_SLOT0:  slot0_reg  <= merge(slot0_reg, w_data_reg, w_strb_reg);
                    `DGC_OFF_SLOT1:  slot1_reg  <= merge(slot1_reg, w_data_reg, w_strb_reg);
                    `DGC_OFF_TIMING: timing_reg <= merge(timing_reg, w_data_reg, w_strb_reg);
                    `DGC_OFF_ADDR:   addr_reg   <= merge(addr_reg, w_data_reg, w_strb_reg);
                    `DGC_OFF_CMD:    cmd_reg    <= merge(cmd_reg, w_data_reg, w_strb_reg);
                    default: begin
                    end
                endcase
            end
        end
    end

    // Illegal population or rate flags a config error and blocks commands.
    // DDR3 needs rate bit 1 (800 MT/s), a clear rate bit is an error; rate bit 0 selects 667 for DDR2 only.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_err_reg <= 1'b0;
        end else begin
            cfg_err_reg <= (ddr3 && !ctrl_reg[`DGC_CTRL_RATE])
                        || !build_ok(slot0_reg, ddr3) || !build_ok(slot1_reg, ddr3)
                        || (slot0_reg[`DGC_SLOT_PRES] && !g0_ok)
                        || (slot1_reg[`DGC_SLOT_PRES] && !g1_ok)
                        || (!slot0_reg[`DGC_SLOT_PRES] && !slot1_reg[`DGC_SLOT_PRES]);
        end
    end

    // Address split: ranks of slot 0 first, then slot 1, any slot may be empty
    always_ff @(posedge aclk) begin
        logic       s1;
        logic [1:0] cb;
        logic [1:0] rb;
        logic       b8;
        logic [3:0] mb;
        logic       dual;
        logic [33:0] off;
        logic [31:0] a;
        s1 = 1'b0;
        a  = addr_reg;
        mb = g0_mb;
        if (!aresetn) begin
            dec_rank_reg <= 2'd0;
            dec_bank_reg <= 3'd0;
            dec_row_reg  <= 14'd0;
            dec_col_reg  <= 10'd0;
            dec_hit_reg  <= 1'b0;
        end else begin
            // 34 bits: two ranks of 2GB make 4GB, which would wrap a 32-bit sum
            off = slot0_reg[`DGC_SLOT_PRES] ?
                  (34'h0010_0000 << g0_mb) << slot0_reg[`DGC_SLOT_DUAL] : 34'h0;
            if ({2'b00, a} >= off) begin
                s1 = 1'b1;
                a  = a - off[31:0];
                mb = g1_mb;
            end
            cb   = s1 ? g1_col : g0_col;
            rb   = s1 ? g1_row : g0_row;
            b8   = s1 ? g1_b8 : g0_b8;
            dual = s1 ? slot1_reg[`DGC_SLOT_DUAL] : slot0_reg[`DGC_SLOT_DUAL];
            // 8 bytes per column beat on the 64-bit channel
            a = a >> 3;
            dec_col_reg  <= cb[0] ? a[9:0] : {1'b0, a[8:0]};
            a = cb[0] ? a >> 10 : a >> 9;
            dec_bank_reg <= b8 ? a[2:0] : {1'b0, a[1:0]};
            a = b8 ? a >> 3 : a >> 2;
            dec_row_reg  <= rb[0] ? a[13:0] : {1'b0, a[12:0]};
            a = rb[0] ? a >> 14 : a >> 13;
            dec_rank_reg <= {s1, dual & a[0]};
            dec_hit_reg  <= (s1 ? slot1_reg[`DGC_SLOT_PRES] : slot0_reg[`DGC_SLOT_PRES])
                            && ({2'b00, addr_reg} < off + ((34'h0010_0000 << mb) << dual));
        end
    end

    // Command sequencer; cmd_reg[0] starts access, [1] write, [2] refresh
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= DGC_IDLE;
            tcnt_reg  <= 8'd0;
            busy_reg  <= 1'b0;
            dram_cmd  <= DGC_C_NOP;
            dram_cs_n <= 4'hf;
            dram_ba   <= 3'd0;
            dram_addr <= 14'd0;
        end else begin
            dram_cmd  <= DGC_C_NOP;
            dram_cs_n <= 4'hf;
            if (tcnt_reg != 8'd0) begin
                tcnt_reg <= tcnt_reg - 8'd1;
            end
            case (state_reg)
                DGC_IDLE: begin
                    busy_reg <= 1'b0;
                    if (go_start) begin
                        busy_reg  <= 1'b1;
                        state_reg <= cmd_reg[2] ? DGC_REF : DGC_ACT;
                    end
                end
                DGC_ACT: begin
                    dram_cmd  <= DGC_C_ACT;
                    dram_cs_n <= ~(4'h1 << dec_rank_reg);
                    dram_ba   <= dec_bank_reg;
                    dram_addr <= dec_row_reg;
                    tcnt_reg  <= timing_reg[23:16];
                    state_reg <= DGC_RCD;
                end
                DGC_RCD: begin
                    if (tcnt_reg <= 8'd1) begin
                        state_reg <= DGC_RW;
                    end
                end
                DGC_RW: begin
                    dram_cmd  <= cmd_reg[1] ? DGC_C_WR : DGC_C_RD;
                    dram_cs_n <= ~(4'h1 << dec_rank_reg);
                    dram_addr <= {4'h0, dec_col_reg};
                    tcnt_reg  <= timing_reg[31:24] + timing_reg[15:8];
                    state_reg <= DGC_RAS;
                end
                DGC_RAS: begin
                    if (tcnt_reg <= 8'd1) begin
                        state_reg <= DGC_PRE;
                    end
                end
                DGC_PRE: begin
                    dram_cmd  <= DGC_C_PRE;
                    dram_cs_n <= ~(4'h1 << dec_rank_reg);
                    dram_ba   <= dec_bank_reg;
                    tcnt_reg  <= timing_reg[7:0];
                    state_reg <= DGC_REF;
                end
                DGC_REF: begin
                    if (tcnt_reg <= 8'd1) begin
                        if (cmd_reg[2] && busy_reg && dram_cmd != DGC_C_REF) begin
                            dram_cmd  <= DGC_C_REF;
                            dram_cs_n <= 4'h0;
                        end
                        state_reg <= DGC_IDLE;
                    end
                end
                default: begin
                    state_reg <= DGC_IDLE;
                end
            endcase
        end
    end

    // DRAM reset pin: low during reset and while asked for in DDR3 mode, high otherwise
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dram_reset_out_n <= 1'b0;
        end else begin
            dram_reset_out_n <= !(ddr3 && ctrl_reg[`DGC_CTRL_DRST]);
        end
    end

    // Read channel, one cycle after address accept
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= 2'b00;
                case (s_axi_araddr)
                    `DGC_OFF_CTRL:   s_axi_rdata <= ctrl_reg;
                    `DGC_OFF_SLOT0:  s_axi_rdata <= slot0_reg;
                    `DGC_OFF_SLOT1:  s_axi_rdata <= slot1_reg;
                    `DGC_OFF_TIMING: s_axi_rdata <= timing_reg;
                    `DGC_OFF_STATUS: s_axi_rdata <= {24'h0, g1_mb[1:0], ranks(slot1_reg),
                                                     ranks(slot0_reg), busy_reg, cfg_err_reg};
                    `DGC_OFF_ADDR:   s_axi_rdata <= addr_reg;
                    `DGC_OFF_DECODE: s_axi_rdata <= {dec_hit_reg, 2'b0, dec_rank_reg,
                                                     dec_bank_reg, dec_row_reg, dec_col_reg};
                    `DGC_OFF_CMD:    s_axi_rdata <= cmd_reg;
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= 2'b10;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    property p_rst_ddr2;
        @(posedge aclk) disable iff (!aresetn) (aresetn && !ddr3) |=> dram_reset_out_n;
    endproperty
    a_rst_ddr2: assert property (p_rst_ddr2) else $error("dram reset low in ddr2");
    property p_err_ddr3_rate;
        @(posedge aclk) disable iff (!aresetn)
            (ddr3 && !ctrl_reg[`DGC_CTRL_RATE]) |=> cfg_err_reg;
    endproperty
    a_err_ddr3_rate: assert property (p_err_ddr3_rate) else $error("ddr3 667 accepted");
    sequence s_act;
        dram_cmd == DGC_C_ACT;
    endsequence
    property p_act_then_rw;
        @(posedge aclk) disable iff (!aresetn)
            s_act |-> ##[1:260] (dram_cmd == DGC_C_RD || dram_cmd == DGC_C_WR);
    endproperty
    a_act_then_rw: assert property (p_act_then_rw) else $error("no access after act");
    property p_one_cs;
        @(posedge aclk) disable iff (!aresetn)
            dram_cmd == DGC_C_ACT |-> $onehot(~dram_cs_n);
    endproperty
    a_one_cs: assert property (p_one_cs) else $error("act not on one rank");
    property p_rst_ddr3;
        @(posedge aclk) disable iff (!aresetn)
            (aresetn && ddr3 && ctrl_reg[`DGC_CTRL_DRST]) |=> !dram_reset_out_n;
    endproperty
    a_rst_ddr3: assert property (p_rst_ddr3) else $error("ddr3 dram reset not low");
    sequence s_rw;
        dram_cmd == DGC_C_RD || dram_cmd == DGC_C_WR;
    endsequence
    property p_rw_then_pre;
        @(posedge aclk) disable iff (!aresetn)
            s_rw |-> ##[1:260] (dram_cmd == DGC_C_PRE);
    endproperty
    a_rw_then_pre: assert property (p_rw_then_pre) else $error("row left open");
endmodule
`default_nettype wire

// ### verif/dgc_dram_model.sv
`timescale 1ns/100ps
`default_nettype none
// Behavioural DRAM channel; it has no data pins, so only commands are judged
module dgc_dram_model
    import dgc_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [3:0] dram_cs_n,
    input  wire logic [2:0] dram_cmd,
    input  wire logic [7:0] trcd,
    output int              errs,
    output int              done_cnt,
    output logic [2:0]      last_rw
);
    logic open_row;
    int   gap;
    // Row state and spacing; a column access too early would read stale data
    always @(posedge aclk) begin
        if (!aresetn) begin
            open_row <= 1'b0;
            gap <= 0;
            errs <= 0;
            done_cnt <= 0;
            last_rw <= 3'h0;
        end else begin
            gap <= gap + 1;
            if (dram_cs_n != 4'hf) begin
                // Refresh goes to every rank at once; all else to exactly one
                if (dram_cmd != DGC_C_REF && $countones(~dram_cs_n) != 1) errs <= errs + 1;
                case (dram_cmd)
                    DGC_C_ACT: begin
                        if (open_row) errs <= errs + 1;
                        open_row <= 1'b1;
                        gap <= 1;
                    end
                    DGC_C_RD, DGC_C_WR: begin
                        if (!open_row || gap < 32'(trcd)) errs <= errs + 1;
                        last_rw <= dram_cmd;
                    end
                    DGC_C_PRE: begin
                        if (!open_row) errs <= errs + 1;
                        open_row <= 1'b0;
                        done_cnt <= done_cnt + 1;
                    end
                    DGC_C_REF: begin
                        if (open_row) errs <= errs + 1;
                        done_cnt <= done_cnt + 1;
                    end
                    default: errs <= errs + 1;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ### verif/tb_dram_geometry_config.sv
`timescale 1ns/100ps
`default_nettype none
`include "dgc_regs.svh"
// Register, geometry and command sequencing checks over AXI4-Lite
module tb_dram_geometry_config;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd, c, s0, s1;
    logic [3:0]  wstrb = 4'hf, cs_n;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, rst_out_n;
    logic [1:0]  bresp, rresp, rs;
    logic [2:0]  cmd, last_rw, ba;
    logic [13:0] daddr;
    int          fails = 0, checks_done = 0, seed = 65, n, k, errs, done_cnt, prev;
    logic [31:0] tc [4] = '{32'h3, 32'h1, 32'h0, 32'hb};
    logic [31:0] t0 [4] = '{32'h17, 32'h11, 32'h07, 32'h03};
    logic [31:0] t1 [4] = '{32'h17, 32'h00, 32'h11, 32'h00};

    always #5 aclk = ~aclk;

    dgc_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .dram_reset_out_n(rst_out_n), .dram_cs_n(cs_n),
        .dram_cmd(cmd), .dram_ba(ba), .dram_addr(daddr));
    dgc_dram_model dram (.aclk(aclk), .aresetn(aresetn), .dram_cs_n(cs_n),
        .dram_cmd(cmd), .trcd(8'h04), .errs(errs), .done_cnt(done_cnt), .last_rw(last_rw));

    // Ranks follow the chip selects a slot has, not component placement
    function automatic logic [1:0] ranks(input logic [31:0] s);
        return s[0] ? (s[1] ? 2'd2 : 2'd1) : 2'd0;
    endfunction
    // A present slot is illegal when its build or rate is outside the supported set
    function automatic logic bad(input logic [31:0] ct, input logic [31:0] s);
        if (!s[0]) return 1'b0;
        if (ct[0]) return !ct[1] || !s[4] || (s[2] != s[1]);
        return s[2] && s[1];
    endfunction
    // Low status bits: rank counts, error for a bad module or for no module at all
    function automatic logic [31:0] exp_status(input logic [31:0] ct, input logic [31:0] a,
                                               input logic [31:0] b);
        return {26'h0, ranks(b), ranks(a), 1'b0, bad(ct, a) | bad(ct, b) | !(a[0] | b[0])};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Address and data offered together; each released once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st);
        int i;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= st;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 60; i++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (i == 60) begin
            fails++;
            report_and_stop();
        end
        rs = bresp;
        bready <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a);
        int i;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 60; i++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (i == 60) begin
            fails++;
            report_and_stop();
        end
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(`DGC_OFF_CTRL);
        check(rd, `DGC_CTRL_RST);
        rdr(`DGC_OFF_TIMING);
        check(rd, `DGC_TIMING_RST);
        check({31'h0, rst_out_n}, 32'h1);
        // Unmapped places answer with an error and no data
        rdr(8'h20);
        check(rd, 32'h0);
        check({30'h0, rs}, 32'h2);
        wr(8'h24, 32'h1234_5678, 4'hf);
        check({30'h0, rs}, 32'h2);
        // Fixed corner builds first, then random ones
        for (k = 0; k < 20; k++) begin
            c = k < 4 ? tc[k] : ($random(seed) & 32'hb);
            s0 = k < 4 ? t0[k] : ($random(seed) & 32'h1f);
            s1 = k < 4 ? t1[k] : ($random(seed) & 32'h1f);
            wr(`DGC_OFF_CTRL, c, 4'hf);
            wr(`DGC_OFF_SLOT0, s0, 4'hf);
            wr(`DGC_OFF_SLOT1, s1, 4'hf);
            rdr(`DGC_OFF_STATUS);
            check(rd & 32'h3f, exp_status(c, s0, s1));
            check({31'h0, rst_out_n}, {31'h0, !(c[0] && c[3])});
        end
        // One timing set; a single-lane write merges into it
        wr(`DGC_OFF_TIMING, 32'h0604_0302, 4'hf);
        wr(`DGC_OFF_TIMING, 32'hffff_ff09, 4'h1);
        rdr(`DGC_OFF_TIMING);
        check(rd, 32'h0604_0309);
        wr(`DGC_OFF_CTRL, 32'h6, 4'hf);
        wr(`DGC_OFF_SLOT0, 32'h11, 4'hf);
        wr(`DGC_OFF_SLOT1, 32'h0, 4'hf);
        wr(`DGC_OFF_ADDR, 32'h0040_6040, 4'hf);
        // 1Gb x8 rank: column 8, bank 3, row 0x40, rank 0, inside slot 0
        rdr(`DGC_OFF_DECODE);
        check(rd, 32'h8301_0008);
        // Read, write and refresh each run to completion on the channel
        for (k = 0; k < 3; k++) begin
            prev = done_cnt;
            wr(`DGC_OFF_CMD, k == 0 ? 32'h1 : (k == 1 ? 32'h3 : 32'h5), 4'hf);
            for (n = 0; n < 300 && done_cnt == prev; n++) @(posedge aclk);
            if (n == 300) begin
                fails++;
                report_and_stop();
            end
            if (k < 2) check({29'h0, last_rw}, k == 0 ? 32'h2 : 32'h3);
        end
        repeat (20) @(posedge aclk);
        rdr(`DGC_OFF_STATUS);
        check(rd & 32'h3, 32'h0);
        check(errs, 32'h0);
        check({29'h0, ba}, 32'h3);
        check({18'h0, daddr}, 32'h8);
        report_and_stop();
    end
endmodule
`default_nettype wire
